// ---- motion_defines.vh ----
// register map, field positions and timing constants of the motion detector
//Contract
//R1: shake tested only on axes enabled for it
//R2: any enabled axis sets one shared shake flag
//R3: shake when sample beyond plus or minus 1.3g
//R4: status read acknowledge clears shake, monitoring restarts
//R5: alert bit high marks returned data invalid
//R6: host picks active rate in rate field
//R7: tap needs tap interrupt enable and rate 000
//R8: tap when transition beats threshold for debounce
//R9: delta-g at any rate with all axes enabled
//R10: below 120 samples per second no tap
//R11: tap interrupt enable gates tap detection
//R12: per-axis tap enables select tested axes
//R13: five-bit tap threshold, 1 to 31 counts
//R14: agreeing tap tests set tap flag, interrupt
//R15: required tests equal debounce value plus one
//R16: tap ORed over axes, flag in bit 5
//R17: tap suspended while tap flag set
//R18: host sets standby, programs, then activates; no mode register here, writes to its address are ignored
//R19: rate field 0x02 means 32 samples per second
//R20: host reads status on interrupt, re-arming detection
//R21: interrupt held while enabled flag pending
//R22: registers reached by byte address over two-wire bus
`ifndef MOTION_DEFINES_VH
`define MOTION_DEFINES_VH

// register byte addresses
`define ADDR_X_SAMPLE 8'h00
`define ADDR_Y_SAMPLE 8'h01
`define ADDR_Z_SAMPLE 8'h02
`define ADDR_STATUS 8'h03
`define ADDR_INT_SETUP 8'h06
`define ADDR_RATE_SEL 8'h08
`define ADDR_TAP_THR 8'h09
`define ADDR_TAP_DEB 8'h0A
`define REG_RESET 8'h00

// field positions
`define SHAKE_EN_X_BIT 7
`define SHAKE_EN_Y_BIT 6
`define SHAKE_EN_Z_BIT 5
`define TAP_IRQ_EN_BIT 3
`define TAP_Z_EN_BIT 7
`define TAP_Y_EN_BIT 6
`define TAP_X_EN_BIT 5
`define TAP_THR_MSB 4
`define RATE_FIELD_MSB 2
`define STAT_SHAKE_BIT 7
`define STAT_ALERT_BIT 6
`define STAT_TAP_BIT 5

// shake limit magnitude in counts (1.3g at 21.33 counts per g)
`define SHAKE_LIMIT 6'h1B

// rates per rate field code, samples per second
`define SPS_0 120
`define SPS_1 64
`define SPS_2 32
`define SPS_3 16
`define SPS_4 8
`define SPS_5 4
`define SPS_6 2
`define SPS_7 1

// timing
`define CLK_HZ 125000000
`define TAP_TEST_NS 260000

// two-wire slave address, value arbitrary
`define BUS_DEV_ADDR 7'h2A

`endif

// ---- pin_sync.v ----
// two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
   parameter WIDTH = 2
) (
   input wire clk,
   input wire nrst,
   input wire [WIDTH-1:0] pin,
   output reg [WIDTH-1:0] sync_q
);
   reg [WIDTH-1:0] meta_q;

   // first stage feeds only the second stage
   always @(posedge clk) begin
      if (!nrst) begin
         meta_q <= {WIDTH{1'b1}};
         sync_q <= {WIDTH{1'b1}};
      end else begin
         meta_q <= pin;
         sync_q <= meta_q;
      end
   end
endmodule

// ---- axis_detect.v ----
// per-axis shake level test and debounced tap transition test
`timescale 1ns/1ps
`include "motion_defines.vh"
module axis_detect (
   input wire clk,
   input wire nrst,
   input wire [5:0] sample,
   input wire rate_tick,
   input wire test_tick,
   input wire shake_en,
   input wire tap_en,
   input wire [4:0] threshold,
   input wire [7:0] debounce,
   output reg shake_q,
   output reg tap_q
);
   reg [5:0] prev_q;
   reg [8:0] agree_q;
   wire signed [5:0] s = sample;
   wire [6:0] delta = {sample[5], sample} - {prev_q[5], prev_q};
   wire [6:0] mag = delta[6] ? (7'h00 - delta) : delta;
   wire exceed = mag > {2'h0, threshold};
   wire [8:0] need = {1'b0, debounce} + 9'h001;
   wire beyond;

   assign beyond = (s > $signed(`SHAKE_LIMIT)) ||
                   (s < -$signed(`SHAKE_LIMIT));

   // shake only on enabled axis, tested each output sample [R1] [R3]
   always @(posedge clk) begin
      if (!nrst) begin
         shake_q <= 1'b0;
      end else begin
         shake_q <= rate_tick & shake_en & beyond; // [R1] [R3]
      end
   end

   // fast transition must agree over debounce+1 tests [R8] [R14] [R15]
   always @(posedge clk) begin
      if (!nrst) begin
         prev_q <= 6'h00;
         agree_q <= 9'h000;
         tap_q <= 1'b0;
      end else begin
         tap_q <= 1'b0;
         if (test_tick) begin
            prev_q <= sample;
            if (tap_en && exceed) begin // [R12] [R13]
               if (agree_q + 9'h001 >= need) begin
                  tap_q <= 1'b1; // [R8] [R15]
                  agree_q <= 9'h000;
               end else begin
                  agree_q <= agree_q + 9'h001; // [R14]
               end
            end else begin
               agree_q <= 9'h000; // a differing test restarts the run
            end
         end
      end
   end
endmodule

// ---- motion_event_detector.v ----
// shake and tap event detector with two-wire register access
`timescale 1ns/1ps
`include "motion_defines.vh"
module motion_event_detector #(
   parameter CLK_HZ = `CLK_HZ
) (
   input wire CLK,
   input wire NRST,
   input wire SCL,
   input wire SDA_IN,
   output reg SDA_OUT,
   output reg SDA_OE,
   input wire [5:0] X_SAMPLE,
   input wire [5:0] Y_SAMPLE,
   input wire [5:0] Z_SAMPLE,
   output reg INT_N
);
   // bus states
   localparam [3:0] S_IDLE = 4'h0;
   localparam [3:0] S_ADDR = 4'h1;
   localparam [3:0] S_AACK = 4'h2;
   localparam [3:0] S_PTR = 4'h3;
   localparam [3:0] S_PACK = 4'h4;
   localparam [3:0] S_WDAT = 4'h5;
   localparam [3:0] S_DACK = 4'h6;
   localparam [3:0] S_RDAT = 4'h7;
   localparam [3:0] S_RACK = 4'h8;

   // tap test spacing, derived from the 0.26 ms test period
   localparam integer TAP_TEST_CYC_RAW = (CLK_HZ / 1000000) *
                                         `TAP_TEST_NS / 1000;
   localparam integer TAP_TEST_CYC = (TAP_TEST_CYC_RAW < 1) ? 1 :
                                     TAP_TEST_CYC_RAW;

   // registers
   reg [7:0] int_setup_q;
   reg [7:0] rate_sel_q;
   reg [7:0] tap_thr_q;
   reg [7:0] tap_deb_q;
   reg [5:0] x_out_q;
   reg [5:0] y_out_q;
   reg [5:0] z_out_q;
   reg shake_flag_q;
   reg tap_flag_q;
   reg alert_q;

   // bus engine
   reg [3:0] state_q;
   reg [3:0] cnt_q;
   reg [7:0] shift_q;
   reg [7:0] tx_q;
   reg [7:0] ptr_q;
   reg rw_q;
   reg mack_q;
   reg scl_prev_q;
   reg sda_prev_q;
   reg wr_q;
   reg [7:0] wr_addr_q;
   reg [7:0] wr_data_q;
   reg status_clr_q;

   // sample timing
   reg [31:0] odr_cnt_q;
   reg [31:0] test_cnt_q;
   reg rate_tick_q;
   reg test_tick_q;

   reg [7:0] rd_data;
   reg [31:0] odr_limit;

   wire [1:0] pins_s;
   wire scl_s = pins_s[1];
   wire sda_s = pins_s[0];
   wire scl_rise = scl_s & ~scl_prev_q;
   wire scl_fall = ~scl_s & scl_prev_q;
   wire bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   wire bus_stop = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

   wire [2:0] rate_field = rate_sel_q[`RATE_FIELD_MSB:0];
   wire shake_en_x = int_setup_q[`SHAKE_EN_X_BIT];
   wire shake_en_y = int_setup_q[`SHAKE_EN_Y_BIT];
   wire shake_en_z = int_setup_q[`SHAKE_EN_Z_BIT];
   wire tap_interrupt_enable = int_setup_q[`TAP_IRQ_EN_BIT];
   wire tap_axis_x_enable = tap_thr_q[`TAP_X_EN_BIT];
   wire tap_axis_y_enable = tap_thr_q[`TAP_Y_EN_BIT];
   wire tap_axis_z_enable = tap_thr_q[`TAP_Z_EN_BIT];
   wire [4:0] tap_threshold_field = tap_thr_q[`TAP_THR_MSB:0];
   wire all_tap_axes = tap_axis_x_enable & tap_axis_y_enable &
                       tap_axis_z_enable;

   // tap runs at the fastest rate, or as delta-g with all axes on,
   // and is held off while an unread tap is pending
   wire tap_run = tap_interrupt_enable & // [R11]
                  ((rate_field == 3'h0) | all_tap_axes) & // [R7] [R9] [R10]
                  ~tap_flag_q; // [R17]

   wire shake_x;
   wire shake_y;
   wire shake_z;
   wire tap_x;
   wire tap_y;
   wire tap_z;
   wire shake_set = shake_x | shake_y | shake_z; // [R2]
   wire tap_set = tap_x | tap_y | tap_z; // [R16]
   wire reading_status = ((state_q == S_RDAT) || (state_q == S_RACK)) &&
                         (ptr_q == `ADDR_STATUS);
   wire collide = (shake_set | tap_set) & reading_status;

   pin_sync #(
      .WIDTH(2)
   ) u_pins (
      .clk(CLK),
      .nrst(NRST),
      .pin({SCL, SDA_IN}),
      .sync_q(pins_s)
   );

   axis_detect u_x (
      .clk(CLK),
      .nrst(NRST),
      .sample(X_SAMPLE),
      .rate_tick(rate_tick_q),
      .test_tick(test_tick_q),
      .shake_en(shake_en_x),
      .tap_en(tap_run & tap_axis_x_enable),
      .threshold(tap_threshold_field),
      .debounce(tap_deb_q),
      .shake_q(shake_x),
      .tap_q(tap_x)
   );

   axis_detect u_y (
      .clk(CLK),
      .nrst(NRST),
      .sample(Y_SAMPLE),
      .rate_tick(rate_tick_q),
      .test_tick(test_tick_q),
      .shake_en(shake_en_y),
      .tap_en(tap_run & tap_axis_y_enable),
      .threshold(tap_threshold_field),
      .debounce(tap_deb_q),
      .shake_q(shake_y),
      .tap_q(tap_y)
   );

   axis_detect u_z (
      .clk(CLK),
      .nrst(NRST),
      .sample(Z_SAMPLE),
      .rate_tick(rate_tick_q),
      .test_tick(test_tick_q),
      .shake_en(shake_en_z),
      .tap_en(tap_run & tap_axis_z_enable),
      .threshold(tap_threshold_field),
      .debounce(tap_deb_q),
      .shake_q(shake_z),
      .tap_q(tap_z)
   );

   // output data rate period from the rate field [R19]
   always @* begin
      case (rate_field)
         3'h0: odr_limit = CLK_HZ / `SPS_0;
         3'h1: odr_limit = CLK_HZ / `SPS_1;
         3'h2: odr_limit = CLK_HZ / `SPS_2; // [R19]
         3'h3: odr_limit = CLK_HZ / `SPS_3;
         3'h4: odr_limit = CLK_HZ / `SPS_4;
         3'h5: odr_limit = CLK_HZ / `SPS_5;
         3'h6: odr_limit = CLK_HZ / `SPS_6;
         default: odr_limit = CLK_HZ / `SPS_7;
      endcase
   end

   // sample and tap-test tick generators
   always @(posedge CLK) begin
      if (!NRST) begin
         odr_cnt_q <= 32'h00000000;
         test_cnt_q <= 32'h00000000;
         rate_tick_q <= 1'b0;
         test_tick_q <= 1'b0;
      end else begin
         rate_tick_q <= 1'b0;
         test_tick_q <= 1'b0;
         // >= so a rate change to a shorter period cannot overrun
         if (odr_cnt_q + 32'h00000001 >= odr_limit) begin
            odr_cnt_q <= 32'h00000000;
            rate_tick_q <= 1'b1;
         end else begin
            odr_cnt_q <= odr_cnt_q + 32'h00000001;
         end
         if (test_cnt_q + 32'h00000001 >= TAP_TEST_CYC) begin
            test_cnt_q <= 32'h00000000;
            test_tick_q <= 1'b1;
         end else begin
            test_cnt_q <= test_cnt_q + 32'h00000001;
         end
      end
   end

   // axis output registers refresh at the output data rate [R6]
   always @(posedge CLK) begin
      if (!NRST) begin
         x_out_q <= 6'h00;
         y_out_q <= 6'h00;
         z_out_q <= 6'h00;
      end else if (rate_tick_q) begin
         x_out_q <= X_SAMPLE;
         y_out_q <= Y_SAMPLE;
         z_out_q <= Z_SAMPLE;
      end
   end

   // event flags: a new event wins over the read clear [R4] [R14]
   always @(posedge CLK) begin
      if (!NRST) begin
         shake_flag_q <= 1'b0;
         tap_flag_q <= 1'b0;
         alert_q <= 1'b0;
      end else begin
         shake_flag_q <= shake_set | (shake_flag_q & ~status_clr_q); // [R2]
         tap_flag_q <= tap_set | (tap_flag_q & ~status_clr_q); // [R16] [R17]
         // an event landing while status shifts out spoils that byte
         alert_q <= collide | (alert_q & ~status_clr_q); // [R5]
      end
   end

   // interrupt pin, push-pull active low, held while enabled flags pend [R21]
   always @(posedge CLK) begin
      if (!NRST) begin
         INT_N <= 1'b1;
      end else begin
         INT_N <= ~((shake_flag_q & (shake_en_x | shake_en_y | shake_en_z)) |
                    (tap_flag_q & tap_interrupt_enable)); // [R3] [R14] [R21]
      end
   end

   // register writes from the bus [R22]
   always @(posedge CLK) begin
      if (!NRST) begin
         int_setup_q <= `REG_RESET;
         rate_sel_q <= `REG_RESET;
         tap_thr_q <= `REG_RESET;
         tap_deb_q <= `REG_RESET;
      end else if (wr_q) begin
         if (wr_addr_q == `ADDR_INT_SETUP) begin
            int_setup_q <= wr_data_q; // [R1] [R11]
         end else if (wr_addr_q == `ADDR_RATE_SEL) begin
            rate_sel_q <= wr_data_q; // [R19]
         end else if (wr_addr_q == `ADDR_TAP_THR) begin
            tap_thr_q <= wr_data_q; // [R12] [R13]
         end else if (wr_addr_q == `ADDR_TAP_DEB) begin
            tap_deb_q <= wr_data_q; // [R15]
         end
      end
   end

   // read data by byte address; unmapped addresses read zero [R22]
   always @* begin
      if (ptr_q == `ADDR_X_SAMPLE) begin
         rd_data = {1'b0, alert_q, x_out_q};
      end else if (ptr_q == `ADDR_Y_SAMPLE) begin
         rd_data = {1'b0, alert_q, y_out_q};
      end else if (ptr_q == `ADDR_Z_SAMPLE) begin
         rd_data = {1'b0, alert_q, z_out_q};
      end else if (ptr_q == `ADDR_STATUS) begin
         rd_data = {shake_flag_q, alert_q, tap_flag_q, 5'h00}; // [R5]
      end else if (ptr_q == `ADDR_INT_SETUP) begin
         rd_data = int_setup_q;
      end else if (ptr_q == `ADDR_RATE_SEL) begin
         rd_data = rate_sel_q;
      end else if (ptr_q == `ADDR_TAP_THR) begin
         rd_data = tap_thr_q;
      end else if (ptr_q == `ADDR_TAP_DEB) begin
         rd_data = tap_deb_q;
      end else begin
         rd_data = 8'h00;
      end
   end

   // two-wire slave: bits sampled on scl rise, driven after scl fall
   always @(posedge CLK) begin
      if (!NRST) begin
         state_q <= S_IDLE;
         cnt_q <= 4'h0;
         shift_q <= 8'h00;
         tx_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         mack_q <= 1'b1;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
         wr_q <= 1'b0;
         wr_addr_q <= 8'h00;
         wr_data_q <= 8'h00;
         status_clr_q <= 1'b0;
         SDA_OUT <= 1'b0;
         SDA_OE <= 1'b0;
      end else begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
         wr_q <= 1'b0;
         status_clr_q <= 1'b0;
         SDA_OUT <= 1'b0; // open drain: only ever pulls low
         if (bus_start) begin
            state_q <= S_ADDR;
            cnt_q <= 4'h0;
            SDA_OE <= 1'b0;
         end else if (bus_stop) begin
            state_q <= S_IDLE;
            SDA_OE <= 1'b0;
         end else if (scl_rise) begin
            case (state_q)
               S_ADDR, S_PTR, S_WDAT: begin
                  if (cnt_q < 4'h8) begin
                     shift_q <= {shift_q[6:0], sda_s};
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
               S_RACK: begin
                  // acknowledge bit of a read: clear after a status read, then move on [R4]
                  mack_q <= sda_s;
                  if (ptr_q == `ADDR_STATUS) begin
                     status_clr_q <= 1'b1; // [R4]
                  end
                  ptr_q <= ptr_q + 8'h01;
               end
               default: begin
               end
            endcase
         end else if (scl_fall) begin
            case (state_q)
               S_ADDR: begin
                  if (cnt_q == 4'h8) begin
                     if (shift_q[7:1] == `BUS_DEV_ADDR) begin
                        rw_q <= shift_q[0];
                        SDA_OE <= 1'b1;
                        state_q <= S_AACK;
                     end else begin
                        state_q <= S_IDLE;
                     end
                  end
               end
               S_AACK: begin
                  if (rw_q) begin
                     tx_q <= {rd_data[6:0], 1'b0};
                     SDA_OE <= ~rd_data[7];
                     cnt_q <= 4'h1;
                     state_q <= S_RDAT;
                  end else begin
                     SDA_OE <= 1'b0;
                     cnt_q <= 4'h0;
                     state_q <= S_PTR;
                  end
               end
               S_PTR: begin
                  if (cnt_q == 4'h8) begin
                     ptr_q <= shift_q;
                     SDA_OE <= 1'b1;
                     state_q <= S_PACK;
                  end
               end
               S_PACK, S_DACK: begin
                  SDA_OE <= 1'b0;
                  cnt_q <= 4'h0;
                  state_q <= S_WDAT;
               end
               S_WDAT: begin
                  if (cnt_q == 4'h8) begin
                     wr_q <= 1'b1; // [R22]
                     wr_addr_q <= ptr_q;
                     wr_data_q <= shift_q;
                     ptr_q <= ptr_q + 8'h01;
                     SDA_OE <= 1'b1;
                     state_q <= S_DACK;
                  end
               end
               S_RDAT: begin
                  if (cnt_q == 4'h8) begin
                     SDA_OE <= 1'b0;
                     state_q <= S_RACK;
                  end else begin
                     SDA_OE <= ~tx_q[7];
                     tx_q <= {tx_q[6:0], 1'b0};
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
               S_RACK: begin
                  // master nack ends the read; ack streams the next byte
                  if (mack_q) begin
                     state_q <= S_IDLE;
                  end else begin
                     tx_q <= {rd_data[6:0], 1'b0};
                     SDA_OE <= ~rd_data[7];
                     cnt_q <= 4'h1;
                     state_q <= S_RDAT;
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end
endmodule

// ---- bus_host_model.sv ----
// two-wire bus host model: open-drain data, clock low 5 cycles, high 5 per bit and 8 per start or stop
`timescale 1ns/1ps
`include "motion_defines.vh"
module bus_host_model #(
   parameter DEV_ADDR = `BUS_DEV_ADDR
) (
   input wire clk,
   input wire sda,
   output reg scl,
   output reg sda_low
);
   // bus idles released, clock high and still between frames
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // one bit slot: data moves while the clock is low, sampled late in high
   task bit_slot(input logic b, output logic r);
      begin
         scl <= 1'b0;
         repeat (2) @(posedge clk);
         sda_low <= ~b;
         repeat (3) @(posedge clk);
         scl <= 1'b1;
         repeat (5) @(posedge clk);
         r = sda;
      end
   endtask

   // start (or repeated start) when is_stop is 0, stop when it is 1
   task cond(input logic is_stop);
      begin
         scl <= 1'b0;
         repeat (2) @(posedge clk);
         sda_low <= is_stop;
         repeat (3) @(posedge clk);
         scl <= 1'b1;
         repeat (3) @(posedge clk);
         sda_low <= ~is_stop;
         repeat (5) @(posedge clk);
      end
   endtask

   // eight bits msb first, then the device's acknowledge slot
   task send_byte(input [7:0] d, output logic nak);
      integer i;
      logic r;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            bit_slot(d[i], r);
         end
         bit_slot(1'b1, nak);
      end
   endtask

   // write one register through the pointer byte
   task write_reg(input [7:0] a, input [7:0] d, output logic ok);
      logic n0, n1, n2;
      begin
         cond(1'b0);
         send_byte({DEV_ADDR, 1'b0}, n0);
         send_byte(a, n1);
         send_byte(d, n2);
         cond(1'b1);
         ok = !(n0 | n1 | n2);
      end
   endtask

   // pointer write, repeated start, one byte read and closed with a nack
   task read_reg(input [7:0] a, output [7:0] d);
      integer i;
      logic n0, r;
      begin
         cond(1'b0);
         send_byte({DEV_ADDR, 1'b0}, n0);
         send_byte(a, n0);
         cond(1'b0);
         send_byte({DEV_ADDR, 1'b1}, n0);
         for (i = 7; i >= 0; i = i - 1) begin
            bit_slot(1'b1, r);
            d[i] = r;
         end
         bit_slot(1'b1, r);
         cond(1'b1);
      end
   endtask
endmodule

// ---- motion_event_detector_asserts.sv ----
// port-level checks of the motion event detector
`timescale 1ns/1ps
module motion_event_detector_asserts #(
   parameter CLK_HZ = 125000000
) (
   input wire CLK,
   input wire NRST,
   input wire SCL,
   input wire SDA_IN,
   input wire SDA_OUT,
   input wire SDA_OE,
   input wire [5:0] X_SAMPLE,
   input wire [5:0] Y_SAMPLE,
   input wire [5:0] Z_SAMPLE,
   input wire INT_N
);
   localparam int TAP_CY = CLK_HZ / 1000000 * 260;
   reg scl_q;
   reg [17:0] samp_q;
   reg [15:0] rise_q, fall_q, chg_q, big_q;
   wire big;

   // a sample beyond the shake limit on any axis
   assign big = (X_SAMPLE[5] ? X_SAMPLE <= 6'h24 : X_SAMPLE >= 6'h1C) ||
                (Y_SAMPLE[5] ? Y_SAMPLE <= 6'h24 : Y_SAMPLE >= 6'h1C) ||
                (Z_SAMPLE[5] ? Z_SAMPLE <= 6'h24 : Z_SAMPLE >= 6'h1C);

   // saturating ages of the last bus clock edges and sample activity
   always @(posedge CLK) begin
      scl_q <= SCL;
      samp_q <= {X_SAMPLE, Y_SAMPLE, Z_SAMPLE};
      if (!NRST) begin
         rise_q <= 16'hFFFF;
         fall_q <= 16'hFFFF;
         chg_q <= 16'hFFFF;
         big_q <= 16'hFFFF;
      end else begin
         rise_q <= (SCL && !scl_q) ? 16'h0000 :
                   rise_q + (rise_q != 16'hFFFF);
         fall_q <= (!SCL && scl_q) ? 16'h0000 :
                   fall_q + (fall_q != 16'hFFFF);
         chg_q <= (samp_q != {X_SAMPLE, Y_SAMPLE, Z_SAMPLE}) ? 16'h0000 :
                  chg_q + (chg_q != 16'hFFFF);
         big_q <= big ? 16'h0000 : big_q + (big_q != 16'hFFFF);
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   a_sda_never_high: assert property (SDA_OUT == 1'b0)
      else $error("data pin driven high");
   a_reset_quiet: assert property ($rose(NRST) |-> INT_N && !SDA_OE)
      else $error("outputs active right after reset");
   a_oe_after_fall: assert property (
      $changed(SDA_OE) |-> fall_q >= 16'd2 && fall_q <= 16'd5)
      else $error("data drive changed away from clock fall");
   a_oe_steady_high: assert property (
      $rose(SCL) |=> $stable(SDA_OE) [*3])
      else $error("data drive changed while clock high");
   a_idle_no_drive: assert property (
      SCL && rise_q > 16'd20 |-> !SDA_OE)
      else $error("data driven on idle bus");
   a_int_held_low: assert property (
      !INT_N && rise_q > 16'd12 && fall_q > 16'd12 |=> !INT_N)
      else $error("interrupt released without bus access");
   a_int_release_bus: assert property (
      $rose(INT_N) |-> rise_q <= 16'd12 || fall_q <= 16'd12)
      else $error("interrupt rose away from a bus access");
   a_int_has_cause: assert property (
      $fell(INT_N) |-> big_q <= 16'd8 || chg_q <= TAP_CY + 8 ||
      fall_q <= 16'd12)
      else $error("interrupt without a shake or transition");

   c_int_fall: cover property ($fell(INT_N));
   c_int_rise: cover property ($rose(INT_N));
   c_oe_rise: cover property ($rose(SDA_OE));
endmodule

bind motion_event_detector motion_event_detector_asserts #(.CLK_HZ(CLK_HZ))
   u_motion_event_detector_asserts (
   .CLK(CLK), .NRST(NRST), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
   .SDA_OE(SDA_OE), .X_SAMPLE(X_SAMPLE), .Y_SAMPLE(Y_SAMPLE),
   .Z_SAMPLE(Z_SAMPLE), .INT_N(INT_N));

// ---- motion_event_detector_tb.sv ----
// self-checking bench: register access, shake and tap scenarios
`timescale 1ns/1ps
`include "motion_defines.vh"
module motion_event_detector_tb;
   localparam SIM_HZ = 1000000;
   localparam TAP_CY = SIM_HZ / 1000000 * 260;
   reg clk;
   reg nrst;
   reg [5:0] x_s;
   reg [5:0] y_s;
   reg [5:0] z_s;
   wire scl, sda_low, sda_out, sda_oe, int_n, sda_wire;
   integer n_mismatch;
   integer tests_run;
   integer i;
   reg [7:0] addr_t [0:5];

   // pulled-up open-drain data line
   assign sda_wire = ~(sda_low | (sda_oe & ~sda_out));

   motion_event_detector #(.CLK_HZ(SIM_HZ)) u_motion_event_detector (
      .CLK(clk), .NRST(nrst), .SCL(scl), .SDA_IN(sda_wire),
      .SDA_OUT(sda_out), .SDA_OE(sda_oe), .X_SAMPLE(x_s), .Y_SAMPLE(y_s),
      .Z_SAMPLE(z_s), .INT_N(int_n));
   bus_host_model u_bus_host_model (.clk(clk), .sda(sda_wire), .scl(scl),
      .sda_low(sda_low));

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task test_done;
      begin
         if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
         end else begin
            $display("Some tests failed");
         end
         $finish;
      end
   endtask

   task chk(input [7:0] got, input [7:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   task wr(input [7:0] a, input [7:0] d);
      logic ok;
      begin
         u_bus_host_model.write_reg(a, d, ok);
         chk({7'h00, ok}, 8'h01);
      end
   endtask

   task rd_chk(input [7:0] a, input [7:0] exp);
      logic [7:0] d;
      begin
         u_bus_host_model.read_reg(a, d);
         chk(d, exp);
      end
   endtask

   // bounded wait for the interrupt; giving up ends the run
   task wait_low(input integer max);
      integer n;
      begin
         n = 0;
         while (int_n !== 1'b0 && n < max) begin
            @(posedge clk);
            n = n + 1;
         end
         if (int_n !== 1'b0) begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: got %h expected 0", $time, int_n);
            test_done;
         end
      end
   endtask

   // k transitions of 20 counts on x, one per tap test period
   task run_tap(input [7:0] su, input [7:0] sr, input [7:0] det,
                input [7:0] deb, input integer k, input logic hit);
      integer j;
      begin
         wr(`ADDR_INT_SETUP, su);
         wr(`ADDR_RATE_SEL, sr);
         wr(`ADDR_TAP_THR, det);
         wr(`ADDR_TAP_DEB, deb);
         repeat (2 * TAP_CY) @(posedge clk);
         for (j = 0; j < k; j = j + 1) begin
            x_s <= x_s ^ 6'h3C;
            repeat (TAP_CY) @(posedge clk);
         end
         repeat (2 * TAP_CY) @(posedge clk);
         chk({7'h00, int_n}, {7'h00, ~(hit & su[3])});
         rd_chk(`ADDR_STATUS, hit ? 8'h20 : 8'h00);
      end
   endtask

   initial begin
      nrst = 1'b0;
      x_s = 6'h36;
      y_s = 6'h00;
      z_s = 6'h00;
      n_mismatch = 0;
      tests_run = 0;
      addr_t[0] = `ADDR_STATUS;
      addr_t[1] = `ADDR_INT_SETUP;
      addr_t[2] = `ADDR_RATE_SEL;
      addr_t[3] = `ADDR_TAP_THR;
      addr_t[4] = `ADDR_TAP_DEB;
      addr_t[5] = 8'h10;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      // reset values, read-back, read-only status and an unmapped address
      for (i = 0; i < 6; i = i + 1) begin
         rd_chk(addr_t[i], `REG_RESET);
         wr(addr_t[i], 8'hA5);
         rd_chk(addr_t[i], (i == 0 || i == 5) ? 8'h00 : 8'hA5);
         wr(addr_t[i], 8'h00);
      end
      // shake on y only; x beyond the limit and y at +27 must stay quiet
      // the mode register has no storage here: standby, then active
      wr(8'h07, 8'h00);
      wr(`ADDR_INT_SETUP, 8'h40);
      wr(8'h07, 8'h41);
      x_s <= 6'h1E;
      y_s <= 6'h1B;
      repeat (9000) @(posedge clk);
      chk({7'h00, int_n}, 8'h01);
      rd_chk(`ADDR_X_SAMPLE, 8'h1E);
      rd_chk(`ADDR_Y_SAMPLE, 8'h1B);
      rd_chk(`ADDR_STATUS, 8'h00);
      y_s <= 6'h22;
      wait_low(9000);
      y_s <= 6'h00;
      x_s <= 6'h36;
      rd_chk(`ADDR_STATUS, 8'h80);
      chk({7'h00, int_n}, 8'h01);
      y_s <= 6'h22;
      wait_low(9000);
      y_s <= 6'h00;
      rd_chk(`ADDR_STATUS, 8'h80);
      // tap cases: debounce, threshold, enables and rate gating
      run_tap(8'h08, 8'h00, 8'h2C, 8'h02, 2, 1'b0);
      run_tap(8'h08, 8'h00, 8'h2C, 8'h02, 3, 1'b1);
      run_tap(8'h08, 8'h00, 8'h2C, 8'h00, 1, 1'b1);
      run_tap(8'h08, 8'h00, 8'h34, 8'h02, 3, 1'b0);
      run_tap(8'h08, 8'h00, 8'h33, 8'h02, 3, 1'b1);
      run_tap(8'h00, 8'h00, 8'h2C, 8'h02, 3, 1'b0);
      run_tap(8'h08, 8'h00, 8'h8C, 8'h02, 3, 1'b0);
      run_tap(8'h08, 8'h02, 8'h2C, 8'h02, 3, 1'b0);
      run_tap(8'h08, 8'h02, 8'hEC, 8'h02, 3, 1'b1);
      test_done;
   end
endmodule
